/* design/eipr_edge_sync.sv */
// Per-line input synchroniser with programmable active edge detection.
// Assumes line inputs may change at any time relative to the clock.
`timescale 1ns/100ps
`include "eipr_map.svh"
module eipr_edge_sync (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [`EIPR_LINES-1:0] line_in,
  input wire logic [`EIPR_LINES-1:0] rising_in,
  output logic [`EIPR_LINES-1:0] level_out,
  output logic [`EIPR_LINES-1:0] edge_out
);
  // ****************************************************************
  // Synchroniser and edge detector, one slice per line.
  // ****************************************************************
  logic [`EIPR_LINES-1:0] meta_reg;
  logic [`EIPR_LINES-1:0] prev_reg;

  genvar g;
  generate
    for (g = 0; g < `EIPR_LINES; g++)
    begin : g_line
      always_ff @(posedge clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
        begin
          meta_reg[g] <= 1'b0;
          level_out[g] <= 1'b0;
          prev_reg[g] <= 1'b0;
          edge_out[g] <= 1'b0;
        end
        else
        begin
          meta_reg[g] <= line_in[g];
          level_out[g] <= meta_reg[g];
          prev_reg[g] <= level_out[g];
          // The edge is taken from the second and third stages, never the first, so metastability cannot leak.
          edge_out[g] <= rising_in[g] ? (level_out[g] & ~prev_reg[g])
                                      : (~level_out[g] & prev_reg[g]);
        end
      end

      chk_edge_single: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        edge_out[g] |=> !edge_out[g])
        else $error("Edge event lasted more than one cycle.");

      chk_edge_cause: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        edge_out[g] |-> $past(level_out[g]) != $past(prev_reg[g])
                        && $past(level_out[g]) == $past(rising_in[g]))
        else $error("Edge event without a matching active edge.");
    end
  endgenerate
endmodule

/* design/eipr_map.svh */
// Offsets, field positions, reset values and timing counts of the interrupt line router.
// Assumes a 25 MHz clock and a byte-addressed APB window of 256 bytes.
`ifndef EIPR_MAP_SVH
`define EIPR_MAP_SVH
`define EIPR_LINES 12
`define EIPR_SRC_COUNT 16
`define EIPR_IDX_W 4
`define EIPR_ADDR_W 8
`define EIPR_OFS_OUT_EN 8'h00
`define EIPR_OFS_TERM 8'h04
`define EIPR_OFS_LEVEL 8'h08
`define EIPR_OFS_POLARITY 8'h0C
`define EIPR_OFS_INT_STATUS 8'h10
`define EIPR_OFS_INT_CLEAR 8'h14
`define EIPR_OFS_INT_ENABLE 8'h18
`define EIPR_OFS_CTRL 8'h1C
`define EIPR_OFS_REF_STATUS 8'h20
`define EIPR_SEL_WINDOW 2'h1
`define EIPR_RST_OUT_EN 12'h03F
`define EIPR_RST_TERM 12'h000
`define EIPR_RST_POLARITY 12'hFFF
`define EIPR_RST_INT_ENABLE 12'h000
`define EIPR_RST_SEL 6'h00
`define EIPR_CTRL_DEDICATED_BIT 0
`define EIPR_CLK_PERIOD_NS 40
`define EIPR_REF_HALF_NS 50
`define EIPR_REF_HALF_CYC (`EIPR_REF_HALF_NS / `EIPR_CLK_PERIOD_NS)
`define EIPR_REF_LOSS_NS 1000
`define EIPR_REF_LOSS_CYC ((`EIPR_REF_LOSS_NS + `EIPR_CLK_PERIOD_NS - 1) / `EIPR_CLK_PERIOD_NS)
`define EIPR_CNT_W 5
`endif

/* design/eipr_pkg.sv */
// Types shared by the interrupt line router files.
// Assumes eipr_map.svh is on the include path.
`include "eipr_map.svh"
package eipr_pkg;
  typedef enum logic [1:0] {SRC_GENERATOR, SRC_TIMER, SRC_EDGE, SRC_DIST} eipr_src_kind_t;

  typedef struct packed {
    eipr_src_kind_t kind;
    logic [`EIPR_IDX_W-1:0] idx;
  } eipr_src_sel_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`EIPR_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } eipr_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } eipr_apb_rsp_t;
endpackage

/* design/eipr_top.sv */
// Top of the external interrupt line router with its APB register file.
// Assumes one 25 MHz clock, synchronous pins and a testbench that resolves each line wire.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "eipr_map.svh"

module eipr_top (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire eipr_pkg::eipr_apb_req_t apb_req_in,
  output eipr_pkg::eipr_apb_rsp_t apb_rsp_out,
  input wire logic [`EIPR_SRC_COUNT-1:0] programmable_interrupt_generator_in,
  input wire logic [`EIPR_SRC_COUNT-1:0] timer_in,
  input wire logic [`EIPR_SRC_COUNT-1:0] dist_in,
  input wire logic [`EIPR_LINES-1:0] ext_interrupt_line_in,
  output logic [`EIPR_LINES-1:0] ext_interrupt_line_out,
  output logic [`EIPR_LINES-1:0] ext_interrupt_line_oe_out,
  output logic [`EIPR_LINES-1:0] term_en_out,
  output logic [`EIPR_LINES-1:0] dedicated_output_line_out,
  input wire logic [`EIPR_LINES-1:0] dedicated_input_line_in,
  input wire logic reference_clock_input_in,
  output logic reference_clock_output_out,
  output logic ref_external_out,
  output logic [`EIPR_LINES-1:0] edge_event_out,
  output logic irq_out
);
  // ****************************************************************
  // Reset release.
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_b;

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_b <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_b <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [`EIPR_LINES-1:0] out_en_reg;
  logic [`EIPR_LINES-1:0] term_reg;
  logic [`EIPR_LINES-1:0] pol_reg;
  logic [`EIPR_LINES-1:0] int_stat_reg;
  logic [`EIPR_LINES-1:0] int_stat_next;
  logic [`EIPR_LINES-1:0] int_en_reg;
  logic ctrl_dedicated_reg;
  eipr_pkg::eipr_src_sel_t sel_reg [`EIPR_LINES];

  logic [`EIPR_LINES-1:0] level;
  logic [`EIPR_LINES-1:0] edge_pulse;
  logic [`EIPR_LINES-1:0] mux_val;
  logic ref_present;

  // ****************************************************************
  // APB slave: one wait-free access phase, errors on unmapped offsets.
  // ****************************************************************
  logic setup;
  logic commit;
  logic wr;
  logic addr_ok;
  logic sel_hit;
  logic [`EIPR_IDX_W-1:0] sel_idx;
  logic [31:0] rd_data;

  assign setup = apb_req_in.psel & ~apb_req_in.penable;
  assign commit = apb_req_in.psel & apb_req_in.penable & apb_rsp_out.pready;
  assign wr = commit & apb_req_in.pwrite & addr_ok;
  assign sel_idx = apb_req_in.paddr[`EIPR_IDX_W+1:2];
  assign sel_hit = (apb_req_in.paddr[7:6] == `EIPR_SEL_WINDOW)
                   && (apb_req_in.paddr[1:0] == 2'h0)
                   && (sel_idx < `EIPR_IDX_W'(`EIPR_LINES));

  always_comb
  begin
    rd_data = 32'h0;
    addr_ok = 1'b1;
    if (sel_hit)
    begin
      rd_data = {26'h0, sel_reg[sel_idx]};
    end
    else
    begin
      unique case (apb_req_in.paddr)
        `EIPR_OFS_OUT_EN: rd_data = {20'h0, out_en_reg};
        `EIPR_OFS_TERM: rd_data = {20'h0, term_reg};
        `EIPR_OFS_LEVEL: rd_data = {20'h0, level};
        `EIPR_OFS_POLARITY: rd_data = {20'h0, pol_reg};
        `EIPR_OFS_INT_STATUS: rd_data = {20'h0, int_stat_reg};
        `EIPR_OFS_INT_CLEAR: rd_data = 32'h0;
        `EIPR_OFS_INT_ENABLE: rd_data = {20'h0, int_en_reg};
        `EIPR_OFS_CTRL: rd_data = {31'h0, ctrl_dedicated_reg};
        `EIPR_OFS_REF_STATUS: rd_data = {31'h0, ref_present};
        default: addr_ok = 1'b0;
      endcase
    end
  end

  // The answer is prepared in the setup cycle, so every access phase lasts one cycle.
  always_ff @(posedge mclk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      apb_rsp_out <= '0;
    end
    else
    begin
      apb_rsp_out.pready <= setup;
      apb_rsp_out.prdata <= (setup && !apb_req_in.pwrite) ? rd_data : 32'h0;
      apb_rsp_out.pslverr <= setup & ~addr_ok;
    end
  end

  // ****************************************************************
  // Direction, termination, polarity, interrupt enable and mode registers.
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_en_reg <= `EIPR_RST_OUT_EN;
      term_reg <= `EIPR_RST_TERM;
      pol_reg <= `EIPR_RST_POLARITY;
      int_en_reg <= `EIPR_RST_INT_ENABLE;
      ctrl_dedicated_reg <= 1'b0;
    end
    else if (wr)
    begin
      if (apb_req_in.paddr == `EIPR_OFS_OUT_EN)
      begin
        out_en_reg <= apb_req_in.pwdata[`EIPR_LINES-1:0];
      end
      if (apb_req_in.paddr == `EIPR_OFS_TERM)
      begin
        term_reg <= apb_req_in.pwdata[`EIPR_LINES-1:0];
      end
      if (apb_req_in.paddr == `EIPR_OFS_POLARITY)
      begin
        pol_reg <= apb_req_in.pwdata[`EIPR_LINES-1:0];
      end
      if (apb_req_in.paddr == `EIPR_OFS_INT_ENABLE)
      begin
        int_en_reg <= apb_req_in.pwdata[`EIPR_LINES-1:0];
      end
      if (apb_req_in.paddr == `EIPR_OFS_CTRL)
      begin
        ctrl_dedicated_reg <= apb_req_in.pwdata[`EIPR_CTRL_DEDICATED_BIT];
      end
    end
  end

  // ****************************************************************
  // Source selection, one field and one multiplexer per line.
  // ****************************************************************
  logic [`EIPR_SRC_COUNT-1:0] level_wide;
  assign level_wide = {{(`EIPR_SRC_COUNT - `EIPR_LINES){1'b0}}, level};
  genvar g;
  generate
    for (g = 0; g < `EIPR_LINES; g++)
    begin : g_sel
      always_ff @(posedge mclk_in or negedge rst_b)
      begin
        if (!rst_b)
        begin
          sel_reg[g] <= eipr_pkg::eipr_src_sel_t'(`EIPR_RST_SEL);
        end
        else if (wr && sel_hit && sel_idx == `EIPR_IDX_W'(g))
        begin
          sel_reg[g] <= eipr_pkg::eipr_src_sel_t'(apb_req_in.pwdata[5:0]);
        end
      end

      // Edge sources above the last line read as zero rather than alias a line.
      always_comb
      begin
        unique case (sel_reg[g].kind)
          eipr_pkg::SRC_GENERATOR:
            mux_val[g] = programmable_interrupt_generator_in[sel_reg[g].idx];
          eipr_pkg::SRC_TIMER: mux_val[g] = timer_in[sel_reg[g].idx];
          eipr_pkg::SRC_EDGE: mux_val[g] = level_wide[sel_reg[g].idx];
          eipr_pkg::SRC_DIST: mux_val[g] = dist_in[sel_reg[g].idx];
        endcase
      end
    end
  endgenerate

  // ****************************************************************
  // Pin drive: shared lines and dedicated outputs.
  // ****************************************************************
  // The driven value keeps running with the gate off, so turning the gate on gives no glitch.
  always_ff @(posedge mclk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_interrupt_line_out <= '0;
      ext_interrupt_line_oe_out <= '0;
      term_en_out <= '0;
      dedicated_output_line_out <= '0;
    end
    else
    begin
      ext_interrupt_line_out <= mux_val;
      ext_interrupt_line_oe_out <= out_en_reg;
      term_en_out <= term_reg;
      dedicated_output_line_out <= mux_val;
    end
  end

  // ****************************************************************
  // Input path and interrupt status.
  // ****************************************************************
  logic [`EIPR_LINES-1:0] in_lines;

  // Outside dedicated mode the shared input is read whatever the gate says, which gives loopback on an open pin.
  assign in_lines = ctrl_dedicated_reg ? dedicated_input_line_in
                                       : ext_interrupt_line_in;

  eipr_edge_sync u_sync (
    .clk_in(mclk_in),
    .rst_b_in(rst_b),
    .line_in(in_lines),
    .rising_in(pol_reg),
    .level_out(level),
    .edge_out(edge_pulse)
  );

  // A new edge wins over a clear of the same bit in the same cycle.
  always_comb
  begin
    int_stat_next = int_stat_reg;
    if (wr && apb_req_in.paddr == `EIPR_OFS_INT_CLEAR)
    begin
      int_stat_next = int_stat_reg & ~apb_req_in.pwdata[`EIPR_LINES-1:0];
    end
    int_stat_next = int_stat_next | edge_pulse;
  end

  always_ff @(posedge mclk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      int_stat_reg <= '0;
      edge_event_out <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      int_stat_reg <= int_stat_next;
      edge_event_out <= edge_pulse;
      irq_out <= |(int_stat_reg & int_en_reg);
    end
  end

  // ****************************************************************
  // Reference clock: external when present, else the internal divider.
  // ****************************************************************
  logic ref_meta_reg;
  logic ref_sync_reg;
  logic ref_prev_reg;
  logic [`EIPR_CNT_W-1:0] loss_cnt_reg;
  logic [`EIPR_CNT_W-1:0] div_cnt_reg;
  logic div_tick;
  logic int_ref_reg;

  assign ref_present = loss_cnt_reg != `EIPR_CNT_W'(`EIPR_REF_LOSS_CYC);
  assign div_tick = div_cnt_reg == `EIPR_CNT_W'(`EIPR_REF_HALF_CYC - 1);

  // A 25 MHz sampler cannot reproduce 10 MHz faithfully; the pass-through is coarse.
  always_ff @(posedge mclk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_meta_reg <= 1'b0;
      ref_sync_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
      loss_cnt_reg <= `EIPR_CNT_W'(`EIPR_REF_LOSS_CYC);
    end
    else
    begin
      ref_meta_reg <= reference_clock_input_in;
      ref_sync_reg <= ref_meta_reg;
      ref_prev_reg <= ref_sync_reg;
      if (ref_sync_reg != ref_prev_reg)
      begin
        loss_cnt_reg <= '0;
      end
      else if (ref_present)
      begin
        loss_cnt_reg <= loss_cnt_reg + `EIPR_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_cnt_reg <= '0;
      int_ref_reg <= 1'b0;
      reference_clock_output_out <= 1'b0;
      ref_external_out <= 1'b0;
    end
    else
    begin
      div_cnt_reg <= div_tick ? '0 : div_cnt_reg + `EIPR_CNT_W'(1);
      if (div_tick)
      begin
        int_ref_reg <= ~int_ref_reg;
      end
      reference_clock_output_out <= ref_present ? ref_sync_reg : int_ref_reg;
      ref_external_out <= ref_present;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  chk_gate_reset: assert property (@(posedge mclk_in) disable iff (!rst_b)
    !$past(rst_b) |-> out_en_reg == `EIPR_RST_OUT_EN ##1 ext_interrupt_line_oe_out == `EIPR_RST_OUT_EN)
    else $error("Output gates not at reset pattern after reset.");

  chk_gate_write: assert property (@(posedge mclk_in) disable iff (!rst_b)
    wr && apb_req_in.paddr == `EIPR_OFS_OUT_EN
    |-> ##2 ext_interrupt_line_oe_out == $past(apb_req_in.pwdata[`EIPR_LINES-1:0], 2))
    else $error("Output gate pins did not follow the written value.");

  chk_term_apart: assert property (@(posedge mclk_in) disable iff (!rst_b)
    wr && apb_req_in.paddr == `EIPR_OFS_OUT_EN |=> $stable(term_reg))
    else $error("Termination changed by a direction write.");

  chk_sel_follow: assert property (@(posedge mclk_in) disable iff (!rst_b)
    sel_reg[0].kind == eipr_pkg::SRC_GENERATOR
    |=> ext_interrupt_line_out[0] == $past(programmable_interrupt_generator_in[sel_reg[0].idx]))
    else $error("Line 0 does not follow its selected generator.");

  chk_dedicated_same: assert property (@(posedge mclk_in) disable iff (!rst_b)
    dedicated_output_line_out == ext_interrupt_line_out)
    else $error("Dedicated outputs differ from the shared line drive.");

  chk_sticky_irq: assert property (@(posedge mclk_in) disable iff (!rst_b)
    |(edge_pulse & int_en_reg) |-> ##2 irq_out)
    else $error("Enabled edge did not raise the interrupt.");

  chk_ref_switch: assert property (@(posedge mclk_in) disable iff (!rst_b)
    ref_sync_reg != ref_prev_reg |=> ##1 ref_external_out)
    else $error("External reference toggling but not selected.");

  chk_ready_one: assert property (@(posedge mclk_in) disable iff (!rst_b)
    setup |=> apb_rsp_out.pready ##1 !apb_rsp_out.pready)
    else $error("Access phase did not last exactly one cycle.");
endmodule

/* sim/eipr_far_end.sv */
// Far-side equipment: drives the input lines, resolves each shared wire, makes a reference clock.
// Assumes the device changes its pins only at rising edges of mclk_in.
`timescale 1ns/100ps
`include "eipr_map.svh"
module eipr_far_end (
  input wire logic mclk_in,
  input wire logic [`EIPR_LINES-1:0] dev_line_in,
  input wire logic [`EIPR_LINES-1:0] dev_oe_in,
  output logic [`EIPR_LINES-1:0] line_out,
  output logic [`EIPR_LINES-1:0] ded_line_out,
  output logic ref_clk_out
);
  // ********
  // Wires
  // ********
  logic [`EIPR_LINES-1:0] attach_reg = '0;
  logic [`EIPR_LINES-1:0] drive_reg = '0;
  logic [`EIPR_LINES-1:0] ded_reg = '0;
  logic flip_reg = 1'b0;
  logic ref_run = 1'b0;
  // A wire nobody drives floats, so it wanders every cycle instead of holding a level.
  always @(posedge mclk_in) flip_reg <= ~flip_reg;
  assign line_out = (attach_reg & drive_reg) | (~attach_reg & dev_oe_in & dev_line_in)
    | (~attach_reg & ~dev_oe_in & {`EIPR_LINES{flip_reg}});
  assign ded_line_out = ded_reg;
  // The reference stands still at low while the equipment has it switched off.
  // Its edges sit 5 ns off a 50 ns grid, so they never meet a rising edge of mclk_in.
  initial
  begin
    ref_clk_out = 1'b0;
    #5;
    forever #50 ref_clk_out = ref_run ? ~ref_clk_out : 1'b0;
  end
  task automatic attach(input logic [`EIPR_LINES-1:0] mask);
    attach_reg <= mask;
  endtask
  task automatic half_pulse(input int ln, input logic ded, input logic val);
    if (ded)
      ded_reg[ln] <= val;
    else
      drive_reg[ln] <= val;
    repeat (25) @(posedge mclk_in);
  endtask
  task automatic ref_enable(input logic on);
    ref_run = on;
  endtask
endmodule

/* sim/testbench.sv */
// Self-checking bench of the interrupt line router: registers, routing, edges, reference.
// Assumes eipr_map.svh on the include path and eipr_far_end compiled before it.
`timescale 1ns/100ps
`include "eipr_map.svh"
module testbench;
  // ********
  // Signals
  // ********
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  eipr_pkg::eipr_apb_req_t req = '0;
  eipr_pkg::eipr_apb_rsp_t rsp;
  logic [15:0] gen = 16'h0000;
  logic [15:0] tmr = 16'h0000;
  logic [15:0] dst = 16'h0000;
  logic [11:0] lin, lout, oe, term, dout, din, ev;
  logic rin, rout, rext, irq, err, r0;
  logic [31:0] rd;
  logic [7:0] bad[2] = '{8'h24, 8'h70};
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int evn = 0;
  int c0, ln, pins;
  int exp_reg[int];
  int sk[6];
  int si[6];
  always #20 mclk_in = ~mclk_in;
  always @(posedge mclk_in) evn <= evn + $countones(ev);
  eipr_top eipr_top_i (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .apb_req_in(req),
    .apb_rsp_out(rsp),
    .programmable_interrupt_generator_in(gen),
    .timer_in(tmr),
    .dist_in(dst),
    .ext_interrupt_line_in(lin),
    .ext_interrupt_line_out(lout),
    .ext_interrupt_line_oe_out(oe),
    .term_en_out(term),
    .dedicated_output_line_out(dout),
    .dedicated_input_line_in(din),
    .reference_clock_input_in(rin),
    .reference_clock_output_out(rout),
    .ref_external_out(rext),
    .edge_event_out(ev),
    .irq_out(irq)
  );
  eipr_far_end eipr_far_end_i (
    .mclk_in(mclk_in),
    .dev_line_in(lout),
    .dev_oe_in(oe),
    .line_out(lin),
    .ded_line_out(din),
    .ref_clk_out(rin)
  );
  // ********
  // Tasks
  // ********
  function automatic logic src(input int k, input int i);
    return k == 0 ? gen[i] : k == 1 ? tmr[i] : k == 3 ? dst[i] : 1'b0;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // The request is held until pready is seen, then one idle edge keeps strobes from toggling twice.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge mclk_in);
    req.penable <= 1'b1;
    do
    begin
      @(posedge mclk_in);
    end
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (wr && exp_reg.exists(a))
      exp_reg[a] = wd & (a >= 'h40 ? 'h3F : a == `EIPR_OFS_CTRL ? 'h1 : 'hFFF);
    @(posedge mclk_in);
  endtask
  task automatic rdc(input int a);
    apb(1'b0, 8'(a), 0);
    chk("reg_read", exp_reg[a], rd);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      errors++;
      $display("mismatch run_length expected %0d seen %0d", 4999, cyc);
      wrap_up();
    end
  end
  // ********
  // Sequence
  // ********
  initial
  begin
    void'($urandom(27652));
    eipr_far_end_i.attach(12'hFC0);
    exp_reg[`EIPR_OFS_OUT_EN] = `EIPR_RST_OUT_EN;
    exp_reg[`EIPR_OFS_TERM] = `EIPR_RST_TERM;
    exp_reg[`EIPR_OFS_POLARITY] = `EIPR_RST_POLARITY;
    exp_reg[`EIPR_OFS_INT_ENABLE] = `EIPR_RST_INT_ENABLE;
    exp_reg[`EIPR_OFS_CTRL] = 0;
    for (int i = 0; i < 12; i++)
      exp_reg['h40 + 4 * i] = `EIPR_RST_SEL;
    repeat (20) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    chk("oe_reset", 'h03F, oe);
    chk("term_reset", 0, term);
    foreach (exp_reg[a])
      rdc(a);
    foreach (bad[k])
    begin
      apb(1'b1, bad[k], 'hFFF);
      chk("bad_err", 1, err);
      apb(1'b0, bad[k], 0);
      chk("bad_read", 0, rd);
    end
    apb(1'b1, `EIPR_OFS_LEVEL, 'hFFF);
    chk("ro_err", 0, err);
    // One of lines 0 to 5 in turn has its source reprogrammed with fresh source levels each pass.
    for (int t = 0; t < 24; t++)
    begin
      ln = t % 6;
      sk[ln] = $urandom_range(3);
      si[ln] = sk[ln] == 2 ? $urandom_range(15, 6) : $urandom_range(15);
      apb(1'b1, 8'('h40 + 4 * ln), 32'(sk[ln] * 16 + si[ln]));
      gen <= 16'($urandom);
      tmr <= 16'($urandom);
      dst <= 16'($urandom);
      repeat (2) @(posedge mclk_in);
      pins = 0;
      for (int i = 0; i < 6; i++)
        pins |= int'(src(sk[i], si[i])) << i;
      chk("line_pins", pins, lout[5:0]);
      chk("dedicated_pins", pins, dout[5:0]);
    end
    repeat (3) @(posedge mclk_in);
    apb(1'b0, `EIPR_OFS_LEVEL, 0);
    chk("level", pins, rd);
    eipr_far_end_i.attach(12'h000);
    apb(1'b1, `EIPR_OFS_OUT_EN, 'hFFF);
    c0 = $urandom & 'hFFF;
    apb(1'b1, `EIPR_OFS_TERM, 32'(c0));
    @(posedge mclk_in);
    chk("oe_all", 'hFFF, oe);
    chk("upper_pins", gen[0] ? 'h3F : 0, lout[11:6]);
    chk("term_pins", c0, term);
    rdc(`EIPR_OFS_OUT_EN);
    rdc(`EIPR_OFS_TERM);
    apb(1'b1, `EIPR_OFS_OUT_EN, 'h03F);
    eipr_far_end_i.attach(12'hFC0);
    apb(1'b1, `EIPR_OFS_INT_ENABLE, 'h080);
    for (int p = 1; p >= 0; p--)
    begin
      apb(1'b1, `EIPR_OFS_POLARITY, p ? 'hFFF : 'hF7F);
      apb(1'b1, `EIPR_OFS_INT_CLEAR, 'hFFF);
      c0 = evn;
      eipr_far_end_i.half_pulse(7, 1'b0, 1'b1);
      chk("edge_rise", p, 32'(evn - c0));
      eipr_far_end_i.half_pulse(7, 1'b0, 1'b0);
      chk("edge_count", 1, 32'(evn - c0));
      apb(1'b0, `EIPR_OFS_INT_STATUS, 0);
      chk("status", 'h080, rd);
      chk("irq_set", 1, irq);
    end
    apb(1'b1, `EIPR_OFS_INT_ENABLE, 0);
    @(posedge mclk_in);
    chk("irq_masked", 0, irq);
    apb(1'b1, `EIPR_OFS_INT_STATUS, 0);
    apb(1'b1, `EIPR_OFS_INT_ENABLE, 'h080);
    @(posedge mclk_in);
    chk("irq_unmasked", 1, irq);
    apb(1'b1, `EIPR_OFS_INT_CLEAR, 'h080);
    apb(1'b0, `EIPR_OFS_INT_STATUS, 0);
    chk("status_clear", 0, rd);
    chk("irq_clear", 0, irq);
    apb(1'b1, `EIPR_OFS_CTRL, 1);
    repeat (6) @(posedge mclk_in);
    apb(1'b1, `EIPR_OFS_INT_CLEAR, 'hFFF);
    c0 = evn;
    eipr_far_end_i.half_pulse(8, 1'b0, 1'b1);
    eipr_far_end_i.half_pulse(9, 1'b1, 1'b1);
    eipr_far_end_i.half_pulse(9, 1'b1, 1'b0);
    chk("ded_edges", 1, 32'(evn - c0));
    apb(1'b0, `EIPR_OFS_INT_STATUS, 0);
    chk("ded_status", 'h200, rd);
    rdc(`EIPR_OFS_CTRL);
    chk("ref_idle", 0, rext);
    r0 = rout;
    @(posedge mclk_in);
    chk("ref_div", !r0, rout);
    eipr_far_end_i.ref_enable(1'b1);
    repeat (20) @(posedge mclk_in);
    chk("ref_found", 1, rext);
    apb(1'b0, `EIPR_OFS_REF_STATUS, 0);
    chk("ref_status", 1, rd);
    eipr_far_end_i.ref_enable(1'b0);
    repeat (40) @(posedge mclk_in);
    chk("ref_lost", 0, rext);
    wrap_up();
  end
endmodule
